// ===== hdl/cgm_mode_ctrl.sv
`timescale 1ns/100ps
module cgm_mode_ctrl #(
	parameter int NUM_W = 24
) (
	input logic clk,
	input logic reset_n,
	input logic [1:0] pageSelectPin,
	input logic [1:0] referenceSelectPin,
	input logic powerDownPinIn,
	input logic multiPinOneIn,
	output logic multiPinOneOut,
	output logic multiPinOneOe,
	input logic multiPinTwoIn,
	output logic multiPinTwoOut,
	output logic multiPinTwoOe,
	input logic multiPinThreeIn,
	input logic multiPinFourIn,
	output logic multiPinFourOut,
	output logic multiPinFourOe,
	input logic [3:0] chanClk,
	output logic nvmLoadReq_q,
	output logic nvmPage_q,
	input logic nvmLoadDone,
	input logic nvmPinMode,
	input logic nvmAddrLsb,
	input logic nvmPdnAsSync,
	input cgm_pkg::cgm_gpio_fn_t nvmPinOneFn,
	input cgm_pkg::cgm_gpio_fn_t nvmPinFourFn,
	input logic [NUM_W-1:0] nvmFracNum,
	input logic globalSleep,
	input logic [3:0] chanSleepCfg,
	input logic pllSleepCfg,
	input logic pllLocked,
	input logic hostRecal,
	input logic sdaPullLow,
	input logic [7:0] addrByte,
	input logic addrByteValid,
	output logic sdaIn_q,
	output logic sclIn_q,
	output logic serialEnable_q,
	output cgm_pkg::cgm_mode_t mode_q,
	output logic [6:0] targetAddr_q,
	output logic addrHit_q,
	output logic addrRead_q,
	output logic calStart_q,
	output logic pllSleep_q,
	output logic [3:0] chanSleep_q,
	output logic bypassSleep_q,
	output logic [3:0] outMute_q,
	output logic sscOn_q,
	output logic [NUM_W-1:0] fracNum_q,
	output logic bootDone_q
);
	import cgm_pkg::*;

	// Numerator steps need at least two bits and must fit one word
	if (NUM_W < 2 || NUM_W > 32)
	begin : gBadNumW
		$error("NUM_W out of range");
	end

	// ***************************************************************
	// Functions
	// ***************************************************************
	function automatic logic fnLevel(
		input cgm_gpio_fn_t fnOne,
		input logic lvlOne,
		input cgm_gpio_fn_t fnFour,
		input logic lvlFour,
		input cgm_gpio_fn_t want,
		input logic dflt
	);
		logic r;
		r = dflt;
		if (fnOne == want)
			r = lvlOne;
		if (fnFour == want)
			r = lvlFour;
		return r;
	endfunction : fnLevel

	function automatic logic isInputFn(input cgm_gpio_fn_t f);
		return (f != FN_LOCK_OUT);
	endfunction : isInputFn

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [1:0] pageLvl;
	logic [1:0] refLvl;
	logic [4:0] pinsSync;
	logic [3:0] chanClkSync;
	logic lockSync;
	logic pdnSync;
	logic pinOneSync;
	logic pinTwoSync;
	logic pinThreeSync;
	logic pinFourSync;

	cgm_sync2 #(.WIDTH(4)) uStrapSync (
		.clk(clk),
		.reset_n(reset_n),
		.async({pageSelectPin, referenceSelectPin}),
		.synced({pageLvl, refLvl})
	);

	cgm_sync2 #(.WIDTH(5)) uPinSync (
		.clk(clk),
		.reset_n(reset_n),
		.async({powerDownPinIn, multiPinOneIn, multiPinTwoIn, multiPinThreeIn, multiPinFourIn}),
		.synced(pinsSync)
	);

	cgm_sync2 #(.WIDTH(5)) uClkSync (
		.clk(clk),
		.reset_n(reset_n),
		.async({pllLocked, chanClk}),
		.synced({lockSync, chanClkSync})
	);

	assign pdnSync = pinsSync[4];
	assign pinOneSync = pinsSync[3];
	assign pinTwoSync = pinsSync[2];
	assign pinThreeSync = pinsSync[1];
	assign pinFourSync = pinsSync[0];

	// ***************************************************************
	// Boot sequence
	// ***************************************************************
	cgm_boot_t boot_q;
	logic [7:0] settleCnt_q;
	logic pdnAsSync_q;
	cgm_gpio_fn_t pinOneFn_q;
	cgm_gpio_fn_t pinFourFn_q;
	logic pdnHold;
	logic isFallback;
	logic isPageMid;
	logic run;

	// Power-down pin holds the boot logic idle unless reconfigured as sync
	assign pdnHold = !pdnSync && !pdnAsSync_q;
	assign isPageMid = (pageLvl == LVL_MID);
	assign isFallback = isPageMid && (refLvl == LVL_MID);
	assign run = (boot_q == ST_RUN);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			boot_q <= ST_HOLD;
			settleCnt_q <= 8'h00;
			nvmLoadReq_q <= 1'b0;
			nvmPage_q <= 1'b0;
			mode_q <= MODE_SERIAL;
			bootDone_q <= 1'b0;
		end
		else if (pdnHold)
		begin
			boot_q <= ST_HOLD;
			settleCnt_q <= 8'h00;
			nvmLoadReq_q <= 1'b0;
			bootDone_q <= 1'b0;
		end
		else
		begin
			case (boot_q)
				ST_HOLD:
				begin
					boot_q <= ST_SETTLE;
					settleCnt_q <= 8'h00;
				end
				ST_SETTLE:
				begin
					if (settleCnt_q == 8'(SETTLE_CYCLES - 1))
					begin
						// Straps are looked at once here, and again only after a reset or a power-down restart
						if (isFallback)
						begin
							mode_q <= MODE_FALLBACK;
							boot_q <= ST_RUN;
							bootDone_q <= 1'b1;
						end
						else if (isPageMid)
						begin
							mode_q <= MODE_SERIAL;
							boot_q <= ST_CAL;
						end
						else
						begin
							nvmPage_q <= (pageLvl == LVL_HIGH);
							nvmLoadReq_q <= 1'b1;
							boot_q <= ST_LOAD;
						end
					end
					else
						settleCnt_q <= settleCnt_q + 8'h01;
				end
				ST_LOAD:
				begin
					if (nvmLoadDone)
					begin
						nvmLoadReq_q <= 1'b0;
						mode_q <= nvmPinMode ? MODE_PIN : MODE_SERIAL;
						boot_q <= ST_CAL;
					end
				end
				ST_CAL:
				begin
					boot_q <= ST_RUN;
					bootDone_q <= 1'b1;
				end
				ST_RUN:
					boot_q <= ST_RUN;
				default:
					boot_q <= ST_HOLD;
			endcase
		end
	end

	// Stored settings captured with the boot, defaults when nothing is read
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pdnAsSync_q <= RST_PDN_AS_SYNC;
			pinOneFn_q <= FALLBACK_PIN_ONE_FN;
			pinFourFn_q <= FALLBACK_PIN_FOUR_FN;
			targetAddr_q <= {ADDR_UPPER, ADDR_LSB_DEFAULT};
		end
		else if (boot_q == ST_SETTLE && settleCnt_q == 8'(SETTLE_CYCLES - 1))
		begin
			pdnAsSync_q <= RST_PDN_AS_SYNC;
			pinOneFn_q <= FALLBACK_PIN_ONE_FN;
			pinFourFn_q <= FALLBACK_PIN_FOUR_FN;
			if (isFallback)
				targetAddr_q <= ADDR_FALLBACK;
			else
				targetAddr_q <= {ADDR_UPPER, ADDR_LSB_DEFAULT};
		end
		else if (boot_q == ST_LOAD && nvmLoadDone)
		begin
			pdnAsSync_q <= nvmPdnAsSync;
			pinOneFn_q <= nvmPinOneFn;
			pinFourFn_q <= isInputFn(nvmPinFourFn) ? nvmPinFourFn : FN_NONE;
			targetAddr_q <= {ADDR_UPPER, nvmAddrLsb};
		end
	end

	// Fall-back never calibrates on its own; a host request still may
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			calStart_q <= 1'b0;
		else
			calStart_q <= (boot_q == ST_CAL) || (run && hostRecal);
	end

	// ***************************************************************
	// Pin routing
	// ***************************************************************
	logic pinMode;
	logic lvlOne;
	logic lvlFour;

	assign pinMode = (mode_q == MODE_PIN) && run;
	// An output-assigned pin reads as low so it never drives a function
	assign lvlOne = isInputFn(pinOneFn_q) & pinOneSync;
	assign lvlFour = pinFourSync;

	// Serial pins are either the bus or enable inputs, never both
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			serialEnable_q <= 1'b0;
			sdaIn_q <= 1'b1;
			sclIn_q <= 1'b1;
			multiPinTwoOut <= 1'b0;
			multiPinTwoOe <= 1'b0;
		end
		else
		begin
			serialEnable_q <= run && !pinMode;
			// Sampling at 200 MHz leaves ample margin at 400 kHz
			sdaIn_q <= pinMode ? 1'b1 : pinTwoSync;
			sclIn_q <= pinMode ? 1'b1 : pinThreeSync;
			multiPinTwoOut <= 1'b0;
			multiPinTwoOe <= run && !pinMode && sdaPullLow;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			multiPinOneOut <= 1'b0;
			multiPinOneOe <= 1'b0;
			multiPinFourOut <= 1'b0;
			multiPinFourOe <= 1'b0;
		end
		else
		begin
			multiPinOneOut <= lockSync;
			multiPinOneOe <= run && !pinMode && (pinOneFn_q == FN_LOCK_OUT);
			// Pin four stays an input in every mode
			multiPinFourOut <= 1'b0;
			multiPinFourOe <= 1'b0;
		end
	end

	// ***************************************************************
	// Address byte check
	// ***************************************************************
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			addrHit_q <= 1'b0;
			addrRead_q <= 1'b0;
		end
		else if (addrByteValid && serialEnable_q)
		begin
			addrHit_q <= (addrByte[7:1] == targetAddr_q);
			addrRead_q <= (addrByte[ADDR_RW_POS] == ADDR_RW_READ);
		end
		else
			addrHit_q <= 1'b0;
	end

	// ***************************************************************
	// Functions driven by pins
	// ***************************************************************
	logic globalOe;
	logic [3:0] indivOe;
	logic stepUpLvl;
	logic stepDownLvl;
	logic stepUpPrev_q;
	logic stepDownPrev_q;

	assign globalOe = pinMode ? 1'b1 :
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_GLOBAL_OE, 1'b1);
	assign indivOe[0] = pinMode ? pinOneSync :
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_OE1, 1'b1);
	assign indivOe[1] = pinMode ? pinTwoSync :
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_OE2, 1'b1);
	assign indivOe[2] = pinMode ? pinThreeSync :
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_OE3, 1'b1);
	assign indivOe[3] = pinMode ? pinFourSync :
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_OE4, 1'b1);
	assign stepUpLvl = !pinMode &&
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_FREQ_UP, 1'b0);
	assign stepDownLvl = !pinMode &&
		fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_FREQ_DOWN, 1'b0);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sscOn_q <= 1'b0;
		else
			sscOn_q <= run && !pinMode &&
				fnLevel(pinOneFn_q, lvlOne, pinFourFn_q, lvlFour, FN_SSC, 1'b0);
	end

	// One step per rising edge; both at once cancel out
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			stepUpPrev_q <= 1'b0;
			stepDownPrev_q <= 1'b0;
			fracNum_q <= '0;
		end
		else
		begin
			stepUpPrev_q <= stepUpLvl;
			stepDownPrev_q <= stepDownLvl;
			if (boot_q == ST_LOAD && nvmLoadDone)
				fracNum_q <= nvmFracNum;
			else if (run && stepUpLvl && !stepUpPrev_q && !(stepDownLvl && !stepDownPrev_q))
				fracNum_q <= fracNum_q + NUM_W'(1);
			else if (run && stepDownLvl && !stepDownPrev_q && !(stepUpLvl && !stepUpPrev_q))
				fracNum_q <= fracNum_q - NUM_W'(1);
		end
	end

	// ***************************************************************
	// Power management
	// ***************************************************************
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pllSleep_q <= RST_SLEEP;
			chanSleep_q <= {4{RST_SLEEP}};
			bypassSleep_q <= RST_SLEEP;
		end
		else
		begin
			pllSleep_q <= globalSleep || pllSleepCfg;
			chanSleep_q <= {4{globalSleep}} | chanSleepCfg;
			bypassSleep_q <= globalSleep || chanSleepCfg[3];
		end
	end

	// ***************************************************************
	// Output enable and mute
	// ***************************************************************
	logic [3:0] enReq;
	logic [3:0] chanActive;
	logic syncMute;

	assign syncMute = pdnAsSync_q && !pdnSync;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : gQual
			assign enReq[gi] = run && globalOe && indivOe[gi] && !chanSleep_q[gi];
			cgm_oe_qual uQual (
				.clk(clk),
				.reset_n(reset_n),
				.enReq(enReq[gi]),
				.chanClk(chanClkSync[gi]),
				.active_q(chanActive[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			outMute_q <= 4'hF;
		else
			outMute_q <= ~chanActive | {4{syncMute}};
	end

endmodule : cgm_mode_ctrl

// ===== hdl/cgm_oe_qual.sv
`timescale 1ns/100ps
module cgm_oe_qual (
	input logic clk,
	input logic reset_n,
	input logic enReq,
	input logic chanClk,
	output logic active_q
);
	import cgm_pkg::*;

	logic chanClkPrev_q;
	logic [2:0] edgeCnt_q;
	logic chanEdge;

	assign chanEdge = chanClk & ~chanClkPrev_q;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			chanClkPrev_q <= 1'b0;
		else
			chanClkPrev_q <= chanClk;
	end

	// Both enabling and disabling wait four channel clock edges, so the
	// channel never cuts a pulse short; a stopped channel clock freezes it
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			edgeCnt_q <= 3'h0;
			active_q <= 1'b0;
		end
		else if (enReq == active_q)
			edgeCnt_q <= 3'h0;
		else if (chanEdge)
		begin
			if (edgeCnt_q == 3'(OE_QUAL_EDGES - 1))
			begin
				active_q <= enReq;
				edgeCnt_q <= 3'h0;
			end
			else
				edgeCnt_q <= edgeCnt_q + 3'h1;
		end
	end

endmodule : cgm_oe_qual

// ===== hdl/cgm_pkg.sv
package cgm_pkg;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STRAP_SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OE_QUAL_EDGES = 4;
	localparam int I2C_FAST_KHZ = 400;
	localparam int I2C_STD_KHZ = 100;

	// ***************************************************************
	// Tri-level strap codes
	// ***************************************************************
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// ***************************************************************
	// Target address
	// ***************************************************************
	localparam logic [6:0] ADDR_FALLBACK = 7'h67;
	localparam logic [5:0] ADDR_UPPER = 6'h34;
	localparam logic ADDR_LSB_DEFAULT = 1'b0;
	localparam int ADDR_RW_POS = 0;
	localparam logic ADDR_RW_READ = 1'b1;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic RST_PDN_AS_SYNC = 1'b0;
	localparam logic RST_SLEEP = 1'b1;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [4:0] {
		ST_HOLD = 5'h01,
		ST_SETTLE = 5'h02,
		ST_LOAD = 5'h04,
		ST_CAL = 5'h08,
		ST_RUN = 5'h10
	} cgm_boot_t;

	typedef enum logic [1:0] {
		MODE_FALLBACK = 2'h0,
		MODE_PIN = 2'h1,
		MODE_SERIAL = 2'h2
	} cgm_mode_t;

	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_FREQ_UP = 4'h1,
		FN_FREQ_DOWN = 4'h2,
		FN_GLOBAL_OE = 4'h3,
		FN_SSC = 4'h4,
		FN_OE1 = 4'h5,
		FN_OE2 = 4'h6,
		FN_OE3 = 4'h7,
		FN_OE4 = 4'h8,
		FN_LOCK_OUT = 4'h9
	} cgm_gpio_fn_t;

	localparam cgm_gpio_fn_t FALLBACK_PIN_ONE_FN = FN_LOCK_OUT;
	localparam cgm_gpio_fn_t FALLBACK_PIN_FOUR_FN = FN_GLOBAL_OE;

endpackage : cgm_pkg

// ===== hdl/cgm_sync2.sv
`timescale 1ns/100ps
module cgm_sync2 #(
	parameter int WIDTH = 1
) (
	input logic clk,
	input logic reset_n,
	input logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			synced <= '0;
		end
		else
		begin
			meta_q <= async;
			synced <= meta_q;
		end
	end

endmodule : cgm_sync2

// ===== sim/cgm_mode_ctrl_assertions.sv
`timescale 1ns/100ps
module cgm_mode_ctrl_checker
	import cgm_pkg::*;
(
	input logic clk,
	input logic reset_n,
	input logic globalSleep,
	input logic pllLocked,
	input logic [7:0] addrByte,
	input logic addrByteValid,
	input logic multiPinOneOut,
	input logic multiPinOneOe,
	input logic multiPinTwoOe,
	input logic multiPinFourOe,
	input logic nvmLoadReq_q,
	input logic serialEnable_q,
	input cgm_pkg::cgm_mode_t mode_q,
	input logic [6:0] targetAddr_q,
	input logic addrHit_q,
	input logic addrRead_q,
	input logic calStart_q,
	input logic pllSleep_q,
	input logic [3:0] chanSleep_q,
	input logic bypassSleep_q,
	input logic bootDone_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	reset_vals_a: assert property (disable iff (1'b0)
		!reset_n |=> targetAddr_q == 7'h68 && !serialEnable_q && !multiPinOneOe)
		else $error("reset values wrong");
	global_sleep_a: assert property (
		globalSleep |-> ##[1:2] (pllSleep_q && chanSleep_q == 4'hF))
		else $error("global sleep ignored");
	bypass_link_a: assert property (bypassSleep_q == chanSleep_q[3])
		else $error("bypass sleep differs from channel four");
	addr_match_a: assert property (addrByteValid && serialEnable_q &&
		addrByte[7:1] == targetAddr_q |=> addrHit_q && addrRead_q == $past(addrByte[0]))
		else $error("address byte not answered");
	fallback_boot_a: assert property ($rose(bootDone_q) && mode_q == MODE_FALLBACK
		|-> targetAddr_q == 7'h67 && !nvmLoadReq_q) else $error("fall-back boot wrong");
	fallback_cal_a: assert property ($rose(bootDone_q) && mode_q == MODE_FALLBACK
		|-> !calStart_q ##1 serialEnable_q) else $error("fall-back calibrated or serial off");
	fallback_pins_a: assert property (bootDone_q && mode_q == MODE_FALLBACK
		|-> ##1 multiPinOneOe && !multiPinFourOe) else $error("fall-back pin directions");
	pin_mode_a: assert property (bootDone_q && mode_q == MODE_PIN
		|-> !serialEnable_q && !multiPinTwoOe) else $error("serial active in pin mode");
	mode_hold_a: assert property (bootDone_q && $past(bootDone_q) |-> $stable(mode_q))
		else $error("mode changed while running");
	lock_out_a: assert property ((bootDone_q && multiPinOneOe && $stable(pllLocked)) [*4]
		|-> multiPinOneOut == pllLocked) else $error("lock output wrong");

	cover property ($rose(bootDone_q) && mode_q == MODE_FALLBACK);
	cover property ($rose(bootDone_q) && mode_q == MODE_PIN);
	cover property (addrHit_q && addrRead_q);
endmodule : cgm_mode_ctrl_checker

bind cgm_mode_ctrl cgm_mode_ctrl_checker cgm_mode_ctrl_checker_i (.*);

// ===== sim/cgm_mode_ctrl_bench.sv
`timescale 1ns/100ps
module cgm_mode_ctrl_bench;
	import cgm_pkg::*;

	localparam int NUM_W = 24;
	localparam int FRAC = 'h100;
	logic clk, reset_n, powerDownPinIn, hostRecal, sdaPullLow, pllLocked, addrByteValid;
	logic [1:0] pageSelectPin, referenceSelectPin;
	logic [3:0] pins, chanClk, chanSleepCfg, chanSleep_q, outMute_q;
	logic multiPinOneOut, multiPinOneOe, multiPinTwoOut, multiPinTwoOe, multiPinFourOut;
	logic multiPinFourOe, nvmLoadReq_q, nvmPage_q, nvmLoadDone, nvmPinMode, nvmAddrLsb;
	logic nvmPdnAsSync, globalSleep, pllSleepCfg, sdaIn_q, sclIn_q, serialEnable_q;
	logic addrHit_q, addrRead_q, calStart_q, pllSleep_q, bypassSleep_q, sscOn_q, bootDone_q;
	logic [7:0] addrByte;
	logic [6:0] targetAddr_q;
	logic [NUM_W-1:0] nvmFracNum, fracNum_q;
	cgm_gpio_fn_t nvmPinOneFn, nvmPinFourFn;
	cgm_mode_t mode_q;
	int loadedPage, nErrors, samplesChecked, seed;
	logic [1:0] pgTab [4] = '{LVL_MID, LVL_MID, LVL_LOW, LVL_HIGH};
	logic [1:0] rfTab [4] = '{LVL_MID, LVL_LOW, LVL_HIGH, LVL_LOW};

	// Pins are pulled up; pin two is open drain
	wire multiPinOneIn = multiPinOneOe ? multiPinOneOut : pins[0];
	wire multiPinTwoIn = pins[1] & ~(multiPinTwoOe & ~multiPinTwoOut);
	wire multiPinThreeIn = pins[2];
	wire multiPinFourIn = multiPinFourOe ? multiPinFourOut : pins[3];

	cgm_mode_ctrl #(.NUM_W(NUM_W)) cgm_mode_ctrl_i (.*);
	cgm_nvm_model #(.NUM_W(NUM_W), .FRAC(FRAC)) cgm_nvm_model_i (.*);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// *******
	// Helpers
	// *******
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	task automatic bound(input int i);
		if (i >= 300)
		begin
			nErrors++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			give_verdict();
		end
	endtask : bound

	task automatic boot(input logic [1:0] pg, input logic [1:0] rf);
		int i;
		reset_n = 1'b0;
		pageSelectPin = pg;
		referenceSelectPin = rf;
		step(6);
		reset_n = 1'b1;
		for (i = 0; i < 300 && bootDone_q !== 1'b1; i++)
			step(1);
		bound(i);
	endtask : boot

	// Flips one enable pin; four channel clock edges are 38 to 62 cycles
	task automatic muteWait(input int pin, input logic [3:0] mask);
		int i;
		pins[pin] = ~pins[pin];
		for (i = 0; i < 300 && outMute_q !== mask; i++)
			step(1);
		bound(i);
		check(i >= 38 && i <= 62, 1'b1);
		check(bypassSleep_q, 1'b0);
	endtask : muteWait

	// *******
	// Main sequence
	// *******
	initial
	begin
		int c, j, fb, pm;
		logic [6:0] expAddr;
		logic [31:0] r;
		logic [7:0] b;
		cgm_mode_t expMode;
		seed = 1238;
		nErrors = 0;
		samplesChecked = 0;
		reset_n = 1'b0;
		pageSelectPin = LVL_MID;
		referenceSelectPin = LVL_MID;
		powerDownPinIn = 1'b1;
		hostRecal = 1'b0;
		sdaPullLow = 1'b0;
		pllLocked = 1'b0;
		addrByte = 8'h00;
		addrByteValid = 1'b0;
		pins = 4'hF;
		globalSleep = 1'b0;
		chanSleepCfg = 4'h0;
		pllSleepCfg = 1'b0;
		for (c = 0; c < 4; c++)
		begin
			fb = pgTab[c] == LVL_MID && rfTab[c] == LVL_MID;
			pm = pgTab[c] == LVL_HIGH;
			expMode = fb ? MODE_FALLBACK : pm ? MODE_PIN : MODE_SERIAL;
			expAddr = fb ? 7'h67 : (pgTab[c] == LVL_LOW) ? 7'h69 : 7'h68;
			boot(pgTab[c], rfTab[c]);
			check(mode_q, expMode);
			check(targetAddr_q, expAddr);
			check(loadedPage, (pgTab[c] != LVL_MID) ? pm : -1);
			check(calStart_q, !fb);
			step(1);
			check(serialEnable_q, !pm);
			for (j = 0; j < 6; j++)
			begin
				r = $random(seed);
				b = j < 2 ? {expAddr, j[0]} : r[7:0];
				addrByte = b;
				addrByteValid = 1'b1;
				step(1);
				check(addrHit_q, !pm && b[7:1] == expAddr);
				if (!pm)
					check(addrRead_q, b[0]);
			end
			addrByteValid = 1'b0;
			for (j = 0; j < 3; j++)
			begin
				r = $random(seed);
				globalSleep = r[4];
				chanSleepCfg = r[3:0];
				pllSleepCfg = r[5];
				step(3);
				check(chanSleep_q, r[3:0] | {4{r[4]}});
				check(pllSleep_q, r[5] | r[4]);
				check(bypassSleep_q, r[3] | r[4]);
			end
			globalSleep = 1'b0;
			chanSleepCfg = 4'h0;
			pllSleepCfg = 1'b0;
			step(3);
			for (j = 0; j < 300 && outMute_q !== 4'h0; j++)
				step(1);
			bound(j);
			check(outMute_q, 4'h0);
			case (c)
				0:
				begin
					for (j = 0; j < 2; j++)
					begin
						pllLocked = j[0];
						step(5);
						check(multiPinOneOut, j[0]);
						check(multiPinOneOe, 1'b1);
					end
					muteWait(3, 4'hF);
					muteWait(3, 4'h0);
					hostRecal = 1'b1;
					step(1);
					check(calStart_q, 1'b1);
					hostRecal = 1'b0;
				end
				1:
				begin
					pins[2:1] = 2'b00;
					step(4);
					check({sdaIn_q, sclIn_q}, 2'b00);
					pins[2:1] = 2'b11;
					sdaPullLow = 1'b1;
					step(5);
					check({multiPinTwoOe, sdaIn_q}, 2'b10);
					sdaPullLow = 1'b0;
					powerDownPinIn = 1'b0;
					step(4);
					check(bootDone_q, 1'b0);
					powerDownPinIn = 1'b1;
					for (j = 0; j < 300 && bootDone_q !== 1'b1; j++)
						step(1);
					bound(j);
					check(targetAddr_q, 7'h68);
				end
				2:
				begin
					for (j = 0; j < 3; j++)
					begin
						pins = {j == 0, 2'b11, j == 1};
						step(5);
						pins = 4'hF;
						step(8);
						check(fracNum_q, FRAC + (j == 0));
					end
				end
				default:
				begin
					muteWait(1, 4'h2);
					muteWait(1, 4'h0);
					muteWait(2, 4'h4);
					muteWait(2, 4'h0);
					check(sscOn_q, 1'b0);
					powerDownPinIn = 1'b0;
					step(4);
					check({bootDone_q, outMute_q}, 5'h1F);
					powerDownPinIn = 1'b1;
					step(4);
					check(outMute_q, 4'h0);
				end
			endcase
			pageSelectPin = pgTab[(c + 1) % 4];
			referenceSelectPin = rfTab[(c + 1) % 4];
			step(30);
			check(mode_q, expMode);
		end
		give_verdict();
	end
endmodule : cgm_mode_ctrl_bench

// ===== sim/cgm_nvm_model.sv
`timescale 1ns/100ps
module cgm_nvm_model
	import cgm_pkg::*;
#(
	parameter int NUM_W = 24,
	parameter int FRAC = 'h100
) (
	input logic clk,
	input logic reset_n,
	input logic nvmLoadReq_q,
	input logic nvmPage_q,
	output logic nvmLoadDone,
	output logic nvmPinMode,
	output logic nvmAddrLsb,
	output logic nvmPdnAsSync,
	output cgm_pkg::cgm_gpio_fn_t nvmPinOneFn,
	output cgm_pkg::cgm_gpio_fn_t nvmPinFourFn,
	output logic [NUM_W-1:0] nvmFracNum,
	output logic [3:0] chanClk,
	output int loadedPage
);
	int waitCnt;

	// *******
	// Channel clocks, free running, unrelated in phase to clk
	// *******
	initial
	begin
		chanClk = 4'h0;
		#3.3;
		forever #32 chanClk = ~chanClk;
	end

	// *******
	// Page contents
	// *******
	// Channel supply-level bits are left to configuration software
	// Outside a load the bit and number words read back inverted; the pin functions read as page one's
	assign nvmPinMode = nvmLoadDone ? nvmPage_q : ~nvmPage_q;
	assign nvmAddrLsb = nvmLoadDone ? ~nvmPage_q : nvmPage_q;
	// Page one turns the power-down pin into the sync input
	assign nvmPdnAsSync = nvmLoadDone ? nvmPage_q : ~nvmPage_q;
	assign nvmPinOneFn = (nvmLoadDone && !nvmPage_q) ? FN_FREQ_UP : FN_LOCK_OUT;
	assign nvmPinFourFn = (nvmLoadDone && !nvmPage_q) ? FN_FREQ_DOWN : FN_SSC;
	assign nvmFracNum = nvmLoadDone ? NUM_W'(FRAC) : ~NUM_W'(FRAC);

	// Page one answers slowly, page zero promptly
	always_ff @(posedge clk)
	begin
		if (!reset_n || !nvmLoadReq_q)
		begin
			waitCnt <= 0;
			nvmLoadDone <= 1'b0;
		end
		else
		begin
			waitCnt <= waitCnt + 1;
			if (waitCnt == (nvmPage_q ? 9 : 1))
				nvmLoadDone <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			loadedPage <= -1;
		else if (nvmLoadDone)
			loadedPage <= int'(nvmPage_q);
	end
endmodule : cgm_nvm_model
